// ===== rtl/ceu_state.sv
// Purpose: architectural state of the execution unit
// Assumes: sequencer and bus unit on mclk; AXI4-Lite for software
// Notes: register outputs straight from flip-flops
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module ceu_state (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire ceu_pkg::ceu_gw_t gpr_wr,
	input wire ceu_pkg::ceu_alu_t alu,
	input wire logic psw_load_valid,
	input wire logic [15:0] psw_load_data,
	input wire logic seg_wr_valid,
	input wire ceu_pkg::ceu_seg_t seg_wr_sel,
	input wire logic [15:0] seg_wr_data,
	input wire logic ip_load_valid,
	input wire logic [15:0] ip_load_data,
	input wire logic str_step,
	input wire logic str_word,
	input wire logic instr_done,
	input wire logic int_req,
	input wire ceu_pkg::ceu_agen_t agen,
	output logic [7:0][15:0] gpr,
	output logic [15:0] io_port_addr,
	output logic [7:0] shift_count,
	output logic [15:0] loop_count,
	output logic [3:0][15:0] seg,
	output logic [15:0] ip,
	output logic [15:0] psw,
	output logic [19:0] fetch_addr,
	output logic [19:0] phys_addr,
	output logic phys_valid,
	output logic int_ack,
	output logic trace_trap
);
	logic [7:0][15:0] next_gpr;
	logic [3:0][15:0] next_seg;
	logic [15:0] next_ip, next_psw;
	logic [19:0] next_fetch, next_phys;
	logic next_phys_valid, next_int_ack, next_trap;
	logic aw_hold, w_hold, next_aw_hold, next_w_hold;
	logic [7:0] aw_addr, next_aw_addr;
	logic [15:0] w_data, next_w_data;
	logic [1:0] w_strb, next_w_strb;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic do_wr;
	logic [15:0] step;

	function automatic logic [19:0] phys(input logic [15:0] s,
		input logic [15:0] o);
		phys = {s, 4'h0} + {4'h0, o};
	endfunction

	function automatic logic rd_hit(input logic [7:0] a);
		rd_hit = a == ceu_pkg::ADDR_PSW || a == ceu_pkg::ADDR_AGEN ||
			a[7:5] == ceu_pkg::ADDR_GPR_HI ||
			a[7:4] == ceu_pkg::ADDR_SEG_HI;
	endfunction

	// general and segment registers
	always_comb begin
		next_gpr = gpr;
		step = str_word ? 16'h0002 : 16'h0001;
		if (str_step) begin
			// index registers move by item size per direction flag
			if (psw[ceu_pkg::DF_BIT]) begin
				next_gpr[ceu_pkg::IDX_SRC] = gpr[ceu_pkg::IDX_SRC] + step;
				next_gpr[ceu_pkg::IDX_DST] = gpr[ceu_pkg::IDX_DST] + step;
			end else begin
				next_gpr[ceu_pkg::IDX_SRC] = gpr[ceu_pkg::IDX_SRC] - step;
				next_gpr[ceu_pkg::IDX_DST] = gpr[ceu_pkg::IDX_DST] - step;
			end
		end
		if (gpr_wr.valid) begin
			if (!gpr_wr.byte_op) begin
				next_gpr[gpr_wr.idx] = gpr_wr.data;
			end else if (gpr_wr.idx[2]) begin
				// byte codes 4..7 are the high halves of words 0..3
				next_gpr[{1'b0, gpr_wr.idx[1:0]}][15:8] = gpr_wr.data[7:0];
			end else begin
				next_gpr[gpr_wr.idx][7:0] = gpr_wr.data[7:0];
			end
		end
		next_seg = seg;
		if (seg_wr_valid) begin
			next_seg[seg_wr_sel] = seg_wr_data;
		end
		// pointer moves only on bus unit load
		next_ip = ip_load_valid ? ip_load_data : ip;
		next_fetch = phys(next_seg[ceu_pkg::SEG_CS], next_ip);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			gpr <= '0;
			seg[ceu_pkg::SEG_CS] <= ceu_pkg::CS_RST;
			seg[ceu_pkg::SEG_DS] <= ceu_pkg::DS_RST;
			seg[ceu_pkg::SEG_SS] <= ceu_pkg::SS_RST;
			seg[ceu_pkg::SEG_ES] <= ceu_pkg::ES_RST;
			ip <= ceu_pkg::IP_RST;
			fetch_addr <= ceu_pkg::FETCH_RST;
		end else begin
			gpr <= next_gpr;
			seg <= next_seg;
			ip <= next_ip;
			fetch_addr <= next_fetch;
		end
	end

	// role views of the general registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			io_port_addr <= '0;
			shift_count <= '0;
			loop_count <= '0;
		end else begin
			io_port_addr <= next_gpr[ceu_pkg::IDX_DAT];
			shift_count <= next_gpr[ceu_pkg::IDX_CNT][7:0];
			loop_count <= next_gpr[ceu_pkg::IDX_CNT];
		end
	end

	// status word: load beats ALU, ALU beats software
	always_comb begin
		next_psw = psw;
		if (do_wr && aw_addr == ceu_pkg::ADDR_PSW) begin
			if (w_strb[0]) begin
				next_psw[7:0] = w_data[7:0];
			end
			if (w_strb[1]) begin
				next_psw[15:8] = w_data[15:8];
			end
		end
		if (alu.valid) begin
			next_psw[ceu_pkg::OF_BIT] = alu.ov;
			next_psw[ceu_pkg::SF_BIT] = alu.word ? alu.res[15]
				: alu.res[7];
			next_psw[ceu_pkg::ZF_BIT] = alu.word ? alu.res == 16'h0000
				: alu.res[7:0] == 8'h00;
			next_psw[ceu_pkg::AF_BIT] = alu.ac;
			next_psw[ceu_pkg::PF_BIT] = ~^alu.res[7:0];
			next_psw[ceu_pkg::CF_BIT] = alu.cy;
		end
		if (psw_load_valid) begin
			next_psw = psw_load_data;
		end
		next_psw = next_psw & ceu_pkg::PSW_MASK;
		// trap uses the flag before this instruction's own load
		next_trap = instr_done && psw[ceu_pkg::TF_BIT];
		next_int_ack = int_req && psw[ceu_pkg::IF_BIT];
		next_phys_valid = agen.valid;
		next_phys = agen.valid ? phys(seg[agen.seg], agen.off)
			: phys_addr;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			psw <= ceu_pkg::PSW_RST;
			trace_trap <= 1'b0;
			int_ack <= 1'b0;
			phys_valid <= 1'b0;
			phys_addr <= '0;
		end else begin
			psw <= next_psw;
			trace_trap <= next_trap;
			int_ack <= next_int_ack;
			phys_valid <= next_phys_valid;
			phys_addr <= next_phys;
		end
	end

	// AXI4-Lite slave
	assign do_wr = aw_hold && w_hold && !s_axi_bvalid;

	always_comb begin
		next_aw_hold = aw_hold;
		next_aw_addr = aw_addr;
		next_w_hold = w_hold;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_hold = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_hold = 1'b1;
			next_w_data = s_axi_wdata[15:0];
			next_w_strb = s_axi_wstrb[1:0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (do_wr) begin
			next_aw_hold = 1'b0;
			next_w_hold = 1'b0;
			next_bvalid = 1'b1;
			// only the status word is writable
			next_bresp = aw_addr == ceu_pkg::ADDR_PSW ? ceu_pkg::RESP_OK
				: ceu_pkg::RESP_ERR;
		end
		next_awready = !next_aw_hold;
		next_wready = !next_w_hold;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rdata = '0;
			next_rresp = rd_hit(s_axi_araddr) ? ceu_pkg::RESP_OK
				: ceu_pkg::RESP_ERR;
			if (s_axi_araddr == ceu_pkg::ADDR_PSW) begin
				next_rdata[15:0] = psw;
			end else if (s_axi_araddr == ceu_pkg::ADDR_AGEN) begin
				next_rdata[19:0] = phys_addr;
			end else if (s_axi_araddr[7:5] == ceu_pkg::ADDR_GPR_HI) begin
				next_rdata[15:0] = gpr[s_axi_araddr[4:2]];
			end else if (s_axi_araddr[7:4] == ceu_pkg::ADDR_SEG_HI) begin
				next_rdata[15:0] = seg[s_axi_araddr[3:2]];
			end
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			aw_hold <= 1'b0;
			aw_addr <= '0;
			w_hold <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ceu_pkg::RESP_OK;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= ceu_pkg::RESP_OK;
		end else begin
			aw_hold <= next_aw_hold;
			aw_addr <= next_aw_addr;
			w_hold <= next_w_hold;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// segment picked by an address request, for the sum check
	logic [15:0] agen_seg_val;
	assign agen_seg_val = seg[agen.seg];

	sequence s_agen_req;
		agen.valid ##1 phys_valid;
	endsequence

	sequence s_released;
		$past(rst);
	endsequence

	a_code_seg_reset: assert property (
		s_released |-> seg[ceu_pkg::SEG_CS] == 16'hFFFF)
		else $error("code segment not FFFF after reset");
	a_data_seg_reset: assert property (
		s_released |-> seg[ceu_pkg::SEG_DS] == 16'h0000 &&
		seg[ceu_pkg::SEG_SS] == 16'h0000)
		else $error("data or stack segment not zero after reset");
	a_extra_seg_reset: assert property (
		s_released |-> seg[ceu_pkg::SEG_ES] == 16'h0000)
		else $error("extra segment not zero after reset");
	a_first_fetch: assert property (
		s_released |-> ip == 16'h0000 && fetch_addr == 20'hFFFF0)
		else $error("first fetch address wrong");
	a_fetch_sum: assert property (
		fetch_addr == {seg[ceu_pkg::SEG_CS], 4'h0} + {4'h0, ip})
		else $error("fetch address not code segment plus pointer");
	a_ip_held: assert property (
		!ip_load_valid |=> $stable(ip))
		else $error("pointer changed without bus unit load");
	a_psw_reserved: assert property (
		(psw & 16'hF02A) == 16'h0000)
		else $error("reserved status bit set");
	a_carry_ovf: assert property (
		alu.valid && !psw_load_valid |=> psw[0] == $past(alu.cy) &&
		psw[4] == $past(alu.ac) && psw[11] == $past(alu.ov))
		else $error("carry, auxiliary or overflow flag wrong");
	a_zero_sign: assert property (
		alu.valid && !psw_load_valid && alu.word |=>
		psw[6] == ($past(alu.res) == 16'h0000) &&
		psw[7] == $past(alu.res[15]))
		else $error("zero or sign flag wrong");
	a_parity_flag: assert property (
		alu.valid && !psw_load_valid |=>
		psw[2] == ~^$past(alu.res[7:0]))
		else $error("parity flag wrong");
	a_int_gate: assert property (
		int_ack |-> $past(int_req) && $past(psw[9]))
		else $error("interrupt accepted while disabled");
	a_int_take: assert property (
		int_req && psw[9] |=> int_ack)
		else $error("enabled interrupt not accepted");
	a_trace_trap: assert property (
		instr_done |=> trace_trap == $past(psw[8]))
		else $error("trace trap mismatch");
	a_step_up: assert property (
		str_step && str_word && psw[10] && !gpr_wr.valid |=>
		gpr[ceu_pkg::IDX_DST] == $past(gpr[ceu_pkg::IDX_DST]) + 16'h0002)
		else $error("string index did not step up");
	a_step_down: assert property (
		str_step && !str_word && !psw[10] && !gpr_wr.valid |=>
		gpr[ceu_pkg::IDX_SRC] == $past(gpr[ceu_pkg::IDX_SRC]) - 16'h0001)
		else $error("string index did not step down");
	a_agen_sum: assert property (
		s_agen_req |-> phys_addr == (({$past(agen_seg_val), 4'h0} +
		{4'h0, $past(agen.off)}) & 20'hFFFFF))
		else $error("physical address wrong");
endmodule

// ===== rtl/ceu_pkg.sv
// Purpose: shared constants and carriers of the execution unit state
// Assumes: AXI4-Lite register window of 256 bytes
// Notes: none
package ceu_pkg;
	localparam logic [7:0] ADDR_PSW = 8'h00;
	localparam logic [7:0] ADDR_AGEN = 8'h04;
	localparam logic [2:0] ADDR_GPR_HI = 3'h1;
	localparam logic [3:0] ADDR_SEG_HI = 4'h4;
	localparam logic [15:0] CS_RST = 16'hFFFF;
	localparam logic [15:0] DS_RST = 16'h0000;
	localparam logic [15:0] SS_RST = 16'h0000;
	localparam logic [15:0] ES_RST = 16'h0000;
	localparam logic [15:0] IP_RST = 16'h0000;
	localparam logic [15:0] PSW_RST = 16'h0000;
	localparam logic [15:0] PSW_MASK = 16'h0FD5;
	localparam logic [19:0] FETCH_RST = 20'hFFFF0;
	localparam int OF_BIT = 11;
	localparam int DF_BIT = 10;
	localparam int IF_BIT = 9;
	localparam int TF_BIT = 8;
	localparam int SF_BIT = 7;
	localparam int ZF_BIT = 6;
	localparam int AF_BIT = 4;
	localparam int PF_BIT = 2;
	localparam int CF_BIT = 0;
	localparam logic [2:0] IDX_CNT = 3'h1;
	localparam logic [2:0] IDX_DAT = 3'h2;
	localparam logic [2:0] IDX_SRC = 3'h6;
	localparam logic [2:0] IDX_DST = 3'h7;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef enum logic [1:0] {SEG_ES, SEG_CS, SEG_SS, SEG_DS} ceu_seg_t;
	typedef struct packed {
		logic valid;
		logic word;
		logic [15:0] res;
		logic cy;
		logic ac;
		logic ov;
	} ceu_alu_t;
	typedef struct packed {
		logic valid;
		logic byte_op;
		logic [2:0] idx;
		logic [15:0] data;
	} ceu_gw_t;
	typedef struct packed {
		logic valid;
		ceu_seg_t seg;
		logic [15:0] off;
	} ceu_agen_t;
endpackage

// ===== test/ceu_seqm.sv
// Purpose: stand-in for the sequencer and bus unit
// Assumes: strobes change just after the rising edge
// Notes: released payloads are inverted, except seg_wr_sel and str_word, which are held
`timescale 1ns/1ps
module ceu_seqm (
	input wire logic mclk,
	output ceu_pkg::ceu_gw_t gpr_wr,
	output ceu_pkg::ceu_alu_t alu,
	output logic psw_load_valid,
	output logic [15:0] psw_load_data,
	output logic seg_wr_valid,
	output ceu_pkg::ceu_seg_t seg_wr_sel,
	output logic [15:0] seg_wr_data,
	output logic ip_load_valid,
	output logic [15:0] ip_load_data,
	output logic str_step,
	output logic str_word,
	output logic instr_done,
	output logic int_req,
	output ceu_pkg::ceu_agen_t agen
);
	initial begin
		{gpr_wr, alu, agen} = '0;
		{psw_load_valid, psw_load_data, seg_wr_valid, seg_wr_data} = '0;
		seg_wr_sel = ceu_pkg::SEG_ES;
		{ip_load_valid, ip_load_data, str_step, str_word} = '0;
		{instr_done, int_req} = '0;
	end
	// one cycle after any strobe: drop valids, scramble payloads other than seg_wr_sel and str_word
	task automatic rel();
		@(posedge mclk);
		gpr_wr <= {1'b0, ~gpr_wr[19:0]};
		alu <= {1'b0, ~alu[19:0]};
		agen <= {1'b0, ~agen[17:0]};
		psw_load_valid <= 1'b0;
		psw_load_data <= ~psw_load_data;
		seg_wr_valid <= 1'b0;
		seg_wr_data <= ~seg_wr_data;
		ip_load_valid <= 1'b0;
		ip_load_data <= ~ip_load_data;
		str_step <= 1'b0;
		instr_done <= 1'b0;
	endtask
	task automatic gw(input logic b, input logic [2:0] i, input logic [15:0] d);
		@(posedge mclk);
		gpr_wr <= {1'b1, b, i, d};
		rel();
	endtask
	task automatic alu_op(input logic w, input logic [15:0] r,
		input logic c, input logic a, input logic o);
		@(posedge mclk);
		alu <= {1'b1, w, r, c, a, o};
		rel();
	endtask
	task automatic psw_ld(input logic [15:0] d, input logic dn);
		@(posedge mclk);
		psw_load_valid <= 1'b1;
		psw_load_data <= d;
		instr_done <= dn;
		rel();
	endtask
	task automatic seg_w(input ceu_pkg::ceu_seg_t s, input logic [15:0] d);
		@(posedge mclk);
		seg_wr_valid <= 1'b1;
		seg_wr_sel <= s;
		seg_wr_data <= d;
		rel();
	endtask
	task automatic ip_ld(input logic [15:0] d);
		@(posedge mclk);
		ip_load_valid <= 1'b1;
		ip_load_data <= d;
		rel();
	endtask
	task automatic step(input logic w);
		@(posedge mclk);
		str_step <= 1'b1;
		str_word <= w;
		rel();
	endtask
	task automatic done();
		@(posedge mclk);
		instr_done <= 1'b1;
		rel();
	endtask
	task automatic ag(input ceu_pkg::ceu_seg_t s, input logic [15:0] o);
		@(posedge mclk);
		agen <= {1'b1, s, o};
		rel();
	endtask
	task automatic set_int(input logic v);
		@(posedge mclk);
		int_req <= v;
	endtask
endmodule

// ===== test/tb.sv
// Purpose: self-checking bench for the execution unit state
// Assumes: sequencer model drives strobes; bench is AXI4-Lite master
// Notes: trap pulses are counted by a monitor
`timescale 1ns/1ps
module tb;
	logic mclk, rst;
	logic [7:0] s_axi_awaddr, s_axi_araddr, shift_count;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, phys_valid, int_ack, trace_trap;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	ceu_pkg::ceu_gw_t gpr_wr;
	ceu_pkg::ceu_alu_t alu;
	ceu_pkg::ceu_agen_t agen;
	ceu_pkg::ceu_seg_t seg_wr_sel;
	logic psw_load_valid, seg_wr_valid, ip_load_valid, str_step;
	logic str_word, instr_done, int_req;
	logic [15:0] psw_load_data, seg_wr_data, ip_load_data, ip, psw;
	logic [15:0] io_port_addr, loop_count;
	logic [7:0][15:0] gpr;
	logic [3:0][15:0] seg;
	logic [19:0] fetch_addr, phys_addr;
	int n_fail, n_tests, n_trap;
	ceu_state u_ceu_state (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gpr_wr, .alu,
		.psw_load_valid, .psw_load_data, .seg_wr_valid, .seg_wr_sel,
		.seg_wr_data, .ip_load_valid, .ip_load_data, .str_step, .str_word,
		.instr_done, .int_req, .agen, .gpr, .io_port_addr, .shift_count,
		.loop_count, .seg, .ip, .psw, .fetch_addr, .phys_addr, .phys_valid,
		.int_ack, .trace_trap);
	ceu_seqm u_ceu_seqm (.mclk, .gpr_wr, .alu, .psw_load_valid,
		.psw_load_data, .seg_wr_valid, .seg_wr_sel, .seg_wr_data,
		.ip_load_valid, .ip_load_data, .str_step, .str_word, .instr_done,
		.int_req, .agen);
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		if (trace_trap === 1'b1) n_trap++;
	end
	task automatic results();
		if (n_fail == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tmo(input int k);
		if (k >= 50) begin
			n_fail++;
			results();
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e);
		int k;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && k < 50);
		s_axi_bready <= 1'b0;
		tmo(k);
		chk("bresp", e, 32'(s_axi_bresp));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e);
		int k;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && k < 50);
		s_axi_rready <= 1'b0;
		tmo(k);
		chk("rresp", e, 32'(s_axi_rresp));
		chk("rdata", d, s_axi_rdata);
	endtask
	task automatic t_reset();
		#1;
		chk("cs", 32'h0000FFFF, 32'(seg[ceu_pkg::SEG_CS]));
		chk("ds", 32'h0, 32'(seg[ceu_pkg::SEG_DS]));
		chk("ss", 32'h0, 32'(seg[ceu_pkg::SEG_SS]));
		chk("es", 32'h0, 32'(seg[ceu_pkg::SEG_ES]));
		chk("ip", 32'h0, 32'(ip));
		chk("fetch", 32'h000FFFF0, 32'(fetch_addr));
		chk("psw", 32'h0, 32'(psw));
	endtask
	task automatic t_gpr();
		u_ceu_seqm.gw(1'b0, 3'h0, 16'h1234);
		u_ceu_seqm.gw(1'b1, 3'h4, 16'h00AB);
		u_ceu_seqm.gw(1'b1, 3'h0, 16'h0011);
		u_ceu_seqm.gw(1'b0, 3'h1, 16'h5678);
		u_ceu_seqm.gw(1'b0, 3'h2, 16'h9ABC);
		#1;
		chk("acc", 32'h0000AB11, 32'(gpr[0]));
		chk("loop", 32'h00005678, 32'(loop_count));
		chk("shift", 32'h00000078, 32'(shift_count));
		chk("io", 32'h00009ABC, 32'(io_port_addr));
		rd(8'h20, 32'h0000AB11, 32'h0);
	endtask
	task automatic t_flags();
		u_ceu_seqm.psw_ld(16'h0000, 1'b0);
		u_ceu_seqm.alu_op(1'b1, 16'h8001, 1'b1, 1'b1, 1'b1);
		#1;
		chk("psw_w", 32'h00000891, 32'(psw));
		chk("psw_ac", 32'h11, 32'(psw & 16'h0011));
		u_ceu_seqm.alu_op(1'b0, 16'h1200, 1'b0, 1'b0, 1'b0);
		#1;
		chk("psw_b", 32'h00000044, 32'(psw));
	endtask
	task automatic t_str();
		u_ceu_seqm.psw_ld(16'h0400, 1'b0);
		u_ceu_seqm.gw(1'b0, 3'h6, 16'h0010);
		u_ceu_seqm.gw(1'b0, 3'h7, 16'h0100);
		u_ceu_seqm.step(1'b1);
		#1;
		chk("src_up", 32'h00000012, 32'(gpr[6]));
		chk("dst_up", 32'h00000102, 32'(gpr[7]));
		u_ceu_seqm.psw_ld(16'h0000, 1'b0);
		u_ceu_seqm.step(1'b0);
		#1;
		chk("src_dn", 32'h00000011, 32'(gpr[6]));
		chk("dst_dn", 32'h00000101, 32'(gpr[7]));
	endtask
	task automatic t_addr();
		u_ceu_seqm.seg_w(ceu_pkg::SEG_DS, 16'hFFFF);
		u_ceu_seqm.ag(ceu_pkg::SEG_DS, 16'h0020);
		#1;
		chk("pv", 32'h1, 32'(phys_valid));
		chk("pa", 32'h00000010, 32'(phys_addr));
		cyc(1);
		chk("pv_end", 32'h0, 32'(phys_valid));
		rd(8'h04, 32'h00000010, 32'h0);
		rd(8'h4C, 32'h0000FFFF, 32'h0);
		u_ceu_seqm.ip_ld(16'h0100);
		cyc(1);
		chk("ip_ld", 32'h00000100, 32'(ip));
		chk("fetch2", 32'h000000F0, 32'(fetch_addr));
	endtask
	task automatic t_int();
		u_ceu_seqm.set_int(1'b1);
		cyc(2);
		chk("ack_off", 32'h0, 32'(int_ack));
		u_ceu_seqm.psw_ld(16'h0200, 1'b0);
		cyc(2);
		chk("ack_on", 32'h1, 32'(int_ack));
		u_ceu_seqm.set_int(1'b0);
	endtask
	task automatic t_trace();
		n_trap = 0;
		u_ceu_seqm.psw_ld(16'h0100, 1'b1);
		cyc(2);
		chk("trap0", 32'h0, 32'(n_trap));
		u_ceu_seqm.done();
		cyc(2);
		chk("trap1", 32'h1, 32'(n_trap));
		u_ceu_seqm.done();
		cyc(2);
		chk("trap2", 32'h2, 32'(n_trap));
	endtask
	task automatic t_axi();
		wr(8'h00, 32'h0000FFFF, 32'h0);
		rd(8'h00, 32'h00000FD5, 32'h0);
		s_axi_wstrb <= 4'h1;
		wr(8'h00, 32'h00000000, 32'h0);
		rd(8'h00, 32'h00000F00, 32'h0);
		s_axi_wstrb <= 4'hF;
		wr(8'h04, 32'h00001234, 32'h2);
		wr(8'h08, 32'h00001234, 32'h2);
		rd(8'h08, 32'h0, 32'h2);
		rd(8'h04, 32'h00000010, 32'h0);
	endtask
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		n_fail = 0;
		n_tests = 0;
		n_trap = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_gpr();
		t_flags();
		t_str();
		t_addr();
		t_int();
		t_trace();
		t_axi();
		// second reset in mid-run, state must return to its reset values
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		rd(8'h00, 32'h0, 32'h0);
		results();
	end
endmodule
